// ===== watchdog_with_reset_flags_tb.sv
// Testbench driving the core end against the device end across one interface.
// Assumes wdg_pkg, wdg_if, wdg_device, wdg_core and the checker are compiled first.
`timescale 1ns/1ps
module watchdog_with_reset_flags_tb;
    import wdg_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic fuse = 1'b0;
    logic [2:0] ev = 3'b000;
    logic c_valid = 1'b0;
    logic [17:0] cmd = 18'h0_0000;
    logic [1:0] c_rv = 2'b00;
    logic c_ready, rsp_valid, irq_seen, rst_pulse;
    logic [7:0] rsp_rdata;
    logic [3:0] ps_out;
    logic [3:0] ps;
    int num_errors = 0;
    int comparisons = 0;
    wdg_if bus_if();
    wdg_device i_wdg_device (.clock(clock), .srst(srst), .bus(bus_if),
        .safety_level_fuse(fuse), .por_event(ev[2]), .bor_event(ev[1]),
        .ext_event(ev[0]), .wdg_reset_pulse(rst_pulse), .prescale_select(ps_out));
    wdg_core i_wdg_core (.clock(clock), .srst(srst), .bus(bus_if), .cmd_valid(c_valid),
        .cmd_write(cmd[17]), .cmd_protected(cmd[16]), .cmd_addr(cmd[15:8]),
        .cmd_wdata(cmd[7:0]), .cmd_restart(c_rv[1]), .cmd_vector(c_rv[0]),
        .cmd_ready(c_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
        .irq_seen(irq_seen));
    wdg_properties i_wdg_properties (.clock(clock), .srst(srst), .wr_en(bus_if.wr_en),
        .rd_en(bus_if.rd_en), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .vector_ack(bus_if.vector_ack), .irq(bus_if.irq),
        .safety_level_fuse(fuse), .wdg_reset_pulse(rst_pulse));

    // ==========================================================
    // Helpers.
    initial begin
        forever #2.5 clock = ~clock;
    end

    function automatic logic [7:0] ctrl_exp(input logic [3:0] p, input logic r);
        return {2'b00, p[3], 1'b0, r, p[2:0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic issue(input logic w, input logic p, input logic [7:0] a,
            input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        c_valid <= 1'b1;
        cmd <= {w, p, a, d};
        @(negedge clock);
        while (c_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        c_valid <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        issue(1'b0, 1'b0, a, 8'h00);
        @(negedge clock);
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        check(rsp_rdata, exp);
    endtask

    task automatic fire(input logic [2:0] e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= 3'b000;
        repeat (2) @(posedge clock);
    endtask

    task automatic give_verdict();
        $display("TB: %0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        num_errors++;
        give_verdict();
    end

    // ==========================================================
    // Tests.
    initial begin
        ps = 4'($urandom(32'hb11c_6615));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        expect_reg(WDG_ADDR_CTRL, 8'h00);
        expect_reg(WDG_ADDR_FLAGS, 8'h01);
        expect_reg(8'($urandom_range(48)), 8'h00);
        $display("TB: reset values done");
        fire(3'b011);
        expect_reg(WDG_ADDR_FLAGS, 8'h07);
        issue(1'b1, 1'b0, WDG_ADDR_FLAGS, 8'hf0);
        expect_reg(WDG_ADDR_FLAGS, 8'h00);
        fire(3'b100);
        fire(3'b010);
        expect_reg(WDG_ADDR_FLAGS, 8'h05);
        fire(3'b100);
        expect_reg(WDG_ADDR_FLAGS, 8'h01);
        $display("TB: reset flags done");
        for (int i = 0; i < 4; i++) begin
            ps = (i == 0) ? WDG_PS_MAX : 4'($urandom_range(9));
            issue(1'b1, 1'b0, WDG_ADDR_CTRL, {2'b00, ps[3], 2'b11, ps[2:0]});
            expect_reg(WDG_ADDR_CTRL, ctrl_exp(ps, 1'b1));
            check({4'h0, ps_out}, {4'h0, ps});
            issue(1'b1, 1'b0, WDG_ADDR_CTRL, 8'h00);
            expect_reg(WDG_ADDR_CTRL, ctrl_exp(4'h0, 1'b1));
            ps = (i == 1) ? 4'h0 : 4'($urandom_range(9));
            issue(1'b1, 1'b1, WDG_ADDR_CTRL, {2'b00, ps[3], 2'b00, ps[2:0]});
            expect_reg(WDG_ADDR_CTRL, ctrl_exp(ps, 1'b0));
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            c_rv <= (i == 0) ? 2'b10 : 2'b01;
            @(posedge clock);
            c_rv <= 2'b00;
        end
        repeat (3) @(posedge clock);
        check({7'h00, irq_seen}, 8'h00);
        expect_reg(WDG_ADDR_CTRL, ctrl_exp(ps, 1'b0));
        $display("TB: level one done");
        @(posedge clock);
        srst <= 1'b1;
        fuse <= 1'b1;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        expect_reg(WDG_ADDR_CTRL, 8'h08);
        issue(1'b1, 1'b0, WDG_ADDR_CTRL, 8'h05);
        expect_reg(WDG_ADDR_CTRL, 8'h08);
        ps = 4'($urandom_range(9));
        issue(1'b1, 1'b1, WDG_ADDR_CTRL, {2'b00, ps[3], 2'b00, ps[2:0]});
        expect_reg(WDG_ADDR_CTRL, ctrl_exp(ps, 1'b1));
        check({7'h00, rst_pulse}, 8'h00);
        $display("TB: level two done");
        give_verdict();
    end
endmodule

// ===== wdg_core.sv
// Core end: issues register accesses, the unlocked write sequence and restarts.
// Assumes the device answers reads one clock after the read strobe.
`timescale 1ns/1ps
module wdg_core (
    input wire logic clock,
    input wire logic srst,
    wdg_if.core bus,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_protected,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_restart,
    input wire logic cmd_vector,
    output logic cmd_ready,
    output logic [7:0] rsp_rdata,
    output logic rsp_valid,
    output logic irq_seen
);
    import wdg_pkg::*;

    typedef struct packed {
        wdg_host_st_t st;
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] hold_addr;
        logic [7:0] hold_data;
        logic restart;
        logic vector_ack;
        logic rd_wait;
        logic [7:0] rsp;
        logic rsp_v;
        logic irq;
        logic ready;
    } wdg_core_state_t;

    wdg_core_state_t s_q;
    wdg_core_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.wr_en = 1'b0;
        s_d.rd_en = 1'b0;
        s_d.restart = cmd_restart;
        // vector only, enable left to software
        s_d.vector_ack = cmd_vector;
        s_d.rsp_v = s_q.rd_wait;
        // Read data stands one cycle after the read strobe.
        s_d.rd_wait = s_q.rd_en;
        if (s_q.rd_wait) begin
            s_d.rsp = bus.rdata;
        end
        s_d.irq = bus.irq;
        case (s_q.st)
            WDG_IDLE: begin
                if (cmd_valid && cmd_write && cmd_protected) begin
                    s_d.hold_addr = cmd_addr;
                    s_d.hold_data = cmd_wdata;
                    s_d.st = WDG_SIG;
                end else if (cmd_valid) begin
                    s_d.wr_en = cmd_write;
                    s_d.rd_en = !cmd_write;
                    s_d.addr = cmd_addr;
                    s_d.wdata = cmd_wdata;
                end
            end
            WDG_SIG: begin
                s_d.wr_en = 1'b1;
                s_d.addr = WDG_ADDR_UNLOCK;
                s_d.wdata = WDG_UNLOCK_SIG;
                s_d.st = WDG_DATA;
            end
            WDG_DATA: begin
                s_d.wr_en = 1'b1;
                s_d.addr = s_q.hold_addr;
                s_d.wdata = s_q.hold_data;
                s_d.st = WDG_IDLE;
            end
            default: begin
                s_d.st = WDG_IDLE;
            end
        endcase
        s_d.ready = (s_d.st == WDG_IDLE);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= WDG_IDLE;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.wr_en = s_q.wr_en;
    assign bus.rd_en = s_q.rd_en;
    assign bus.addr = s_q.addr;
    assign bus.wdata = s_q.wdata;
    assign bus.restart = s_q.restart;
    assign bus.vector_ack = s_q.vector_ack;
    assign bus.instr_tick = 1'b1;
    assign cmd_ready = s_q.ready;
    assign rsp_rdata = s_q.rsp;
    assign rsp_valid = s_q.rsp_v;
    assign irq_seen = s_q.irq;

endmodule

// ===== wdg_device.sv
// Watchdog with fuse-selected safety level, timed unlock, and reset-cause flags.
// Assumes the core drives the interface on the same clock; reset causes come as pulses.
//
// How it works
// - Counter ticks from a 128 kHz enable.
// - Restart, disable or reset clears counter.
// - Time-out with reset action resets device.
// - Level one: disable needs unlocked write.
// - Level two: always reset, enable reads one.
// - Level two: prescale changes only when unlocked.
// - Software writes 0xD8 signature first.
// - Enable bits select stopped, irq, reset, both.
// - Time-out in irq mode sets flag.
// - Flag clears on vector or written one.
// - Request while flag and enable set.
// - Vector in combined mode clears enable, flag.
// - Second unserviced time-out resets device.
// - Software re-enables irq outside handler.
// - Reset flag forces reset enable on.
// - Prescale code doubles count from 2048.
// - Other flags set by source, cleared.
// - Power-on flag cleared only by software.
// - Reserved bits read as zero.
// - Software reads and clears flags early.
// - Watchdog reset is one clock pulse.
`timescale 1ns/1ps
module wdg_device (
    input wire logic clock,
    input wire logic srst,
    wdg_if.device bus,
    input wire logic safety_level_fuse,
    input wire logic por_event,
    input wire logic bor_event,
    input wire logic ext_event,
    output logic wdg_reset_pulse,
    output logic [3:0] prescale_select
);
    import wdg_pkg::*;

    typedef struct packed {
        logic [10:0] osc_div;
        logic [19:0] count;
        logic irq_flag;
        logic irq_en;
        logic rst_en;
        logic [3:0] ps;
        logic [3:0] unlock_cnt;
        logic wdrf;
        logic brownout_reset_flag;
        logic external_reset_flag;
        logic poweron_reset_flag;
        logic [7:0] rdata;
        logic irq;
        logic rst_pulse;
    } wdg_state_t;

    wdg_state_t st_q;
    wdg_state_t st_d;
    logic osc_tick;
    logic timeout;
    logic [19:0] limit;
    logic unlocked;
    logic rst_en_eff;
    logic run;
    logic dev_reset;
    logic wr_ctrl;
    logic wr_flags;
    logic [7:0] ctrl_view;
    logic [7:0] flags_view;

    always_comb begin
        st_d = st_q;
        // ==========================================================
        // oscillator enable divider
        osc_tick = (st_q.osc_div == 11'(WDG_OSC_DIV - 1));
        st_d.osc_div = osc_tick ? 11'h000 : st_q.osc_div + 11'h001;

        limit = WDG_BASE_COUNT << st_q.ps;
        unlocked = (st_q.unlock_cnt != 4'h0);
        rst_en_eff = st_q.rst_en | st_q.wdrf | safety_level_fuse;
        run = rst_en_eff | st_q.irq_en;
        timeout = run && osc_tick && (st_q.count == limit - 20'h1);
        dev_reset = por_event | bor_event | ext_event | st_q.rst_pulse;
        wr_ctrl = bus.wr_en && (bus.addr == WDG_ADDR_CTRL);
        wr_flags = bus.wr_en && (bus.addr == WDG_ADDR_FLAGS);

        // ==========================================================
        // counter clears
        if (bus.restart || !run || dev_reset) begin
            st_d.count = 20'h0_0000;
        end else if (osc_tick) begin
            st_d.count = timeout ? 20'h0_0000 : st_q.count + 20'h0_0001;
        end

        if (bus.wr_en && bus.addr == WDG_ADDR_UNLOCK && bus.wdata == WDG_UNLOCK_SIG) begin
            st_d.unlock_cnt = WDG_UNLOCK_WINDOW;
        end else if (unlocked && (bus.instr_tick || wr_ctrl)) begin
            st_d.unlock_cnt = wr_ctrl ? 4'h0 : st_q.unlock_cnt - 4'h1;
        end

        // ==========================================================
        // Control register write.
        st_d.rst_pulse = 1'b0;
        if (wr_ctrl) begin
            st_d.irq_en = bus.wdata[WDG_BIT_IRQ_EN];
            if (!safety_level_fuse && (bus.wdata[WDG_BIT_RST_EN] || unlocked)) begin
                st_d.rst_en = bus.wdata[WDG_BIT_RST_EN];
            end
            if (!safety_level_fuse || unlocked) begin
                st_d.ps = {bus.wdata[WDG_BIT_PS3], bus.wdata[2:0]};
            end
        end
        if (st_q.wdrf) begin
            st_d.rst_en = 1'b1;
        end
        if (wr_ctrl && bus.wdata[WDG_BIT_IRQ_FLAG]) begin
            st_d.irq_flag = 1'b0;
        end
        if (bus.vector_ack) begin
            st_d.irq_flag = 1'b0;
            if (rst_en_eff) begin
                st_d.irq_en = 1'b0;
            end
        end

        // ==========================================================
        if (timeout) begin
            if (rst_en_eff && (!st_q.irq_en || st_q.irq_flag)) begin
                st_d.rst_pulse = 1'b1;
            end else if (st_q.irq_en) begin
                st_d.irq_flag = 1'b1;
            end
        end

        // ==========================================================
        // source flags
        if (wr_flags) begin
            st_d.wdrf = st_q.wdrf & bus.wdata[WDG_BIT_WDRF];
            st_d.brownout_reset_flag = st_q.brownout_reset_flag & bus.wdata[WDG_BIT_BROWNOUT_RESET_FLAG];
            st_d.external_reset_flag = st_q.external_reset_flag & bus.wdata[WDG_BIT_EXTERNAL_RESET_FLAG];
            st_d.poweron_reset_flag = st_q.poweron_reset_flag & bus.wdata[WDG_BIT_POWERON_RESET_FLAG];
        end
        if (st_q.rst_pulse) begin
            st_d.wdrf = 1'b1;
        end
        if (bor_event) begin
            st_d.brownout_reset_flag = 1'b1;
        end
        if (ext_event) begin
            st_d.external_reset_flag = 1'b1;
        end
        if (por_event) begin
            st_d.wdrf = 1'b0;
            st_d.brownout_reset_flag = 1'b0;
            st_d.external_reset_flag = 1'b0;
            st_d.poweron_reset_flag = 1'b1;
        end
        // A device reset returns control state to its initial values.
        if (dev_reset) begin
            st_d.irq_flag = 1'b0;
            st_d.irq_en = 1'b0;
            st_d.rst_en = 1'b0;
            st_d.ps = 4'h0;
            st_d.unlock_cnt = 4'h0;
        end

        // ==========================================================
        // reserved bits zero
        ctrl_view = {st_q.irq_flag, st_q.irq_en, st_q.ps[3], 1'b0, rst_en_eff, st_q.ps[2:0]};
        flags_view = {4'h0, st_q.wdrf, st_q.brownout_reset_flag, st_q.external_reset_flag, st_q.poweron_reset_flag};
        if (bus.rd_en && bus.addr == WDG_ADDR_CTRL) begin
            st_d.rdata = ctrl_view;
        end else if (bus.rd_en && bus.addr == WDG_ADDR_FLAGS) begin
            st_d.rdata = flags_view;
        end else begin
            st_d.rdata = 8'h00;
        end
        st_d.irq = st_d.irq_flag & st_d.irq_en;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
            st_q.poweron_reset_flag <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.rdata = st_q.rdata;
    assign bus.irq = st_q.irq;
    assign wdg_reset_pulse = st_q.rst_pulse;
    assign prescale_select = st_q.ps;

endmodule

// ===== wdg_if.sv
// Interface joining the watchdog register port and restart line to the core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface wdg_if;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic restart;
    logic vector_ack;
    logic irq;
    logic instr_tick;

    modport device (
        input wr_en,
        input rd_en,
        input addr,
        input wdata,
        input restart,
        input vector_ack,
        input instr_tick,
        output rdata,
        output irq
    );

    modport core (
        output wr_en,
        output rd_en,
        output addr,
        output wdata,
        output restart,
        output vector_ack,
        output instr_tick,
        input rdata,
        input irq
    );
endinterface

// ===== wdg_pkg.sv
// Package of constants and types shared by the watchdog device end and the core end.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package wdg_pkg;

    // ==========================================================
    // Register map.
    localparam logic [7:0] WDG_ADDR_CTRL = 8'h31;
    localparam logic [7:0] WDG_ADDR_FLAGS = 8'h3b;
    localparam logic [7:0] WDG_ADDR_UNLOCK = 8'h3c;
    localparam logic [7:0] WDG_UNLOCK_SIG = 8'hd8;

    // ==========================================================
    // Field positions of the control and status register.
    localparam int WDG_BIT_IRQ_FLAG = 7;
    localparam int WDG_BIT_IRQ_EN = 6;
    localparam int WDG_BIT_PS3 = 5;
    localparam int WDG_BIT_RST_EN = 3;

    // Field positions of the reset cause register.
    localparam int WDG_BIT_WDRF = 3;
    localparam int WDG_BIT_BROWNOUT_RESET_FLAG = 2;
    localparam int WDG_BIT_EXTERNAL_RESET_FLAG = 1;
    localparam int WDG_BIT_POWERON_RESET_FLAG = 0;

    // ==========================================================
    // Timing.
    localparam int WDG_SYS_HZ = 200_000_000;
    localparam int WDG_OSC_HZ = 128_000;
    localparam int WDG_OSC_DIV = WDG_SYS_HZ / WDG_OSC_HZ;
    localparam logic [3:0] WDG_UNLOCK_WINDOW = 4'h4;
    localparam logic [3:0] WDG_PS_MAX = 4'h9;
    localparam logic [19:0] WDG_BASE_COUNT = 20'h0_0800;

    // ==========================================================
    // Core end command states.
    typedef enum logic [1:0] {
        WDG_IDLE,
        WDG_SIG,
        WDG_DATA
    } wdg_host_st_t;

endpackage

// ===== wdg_properties.sv
// Checker for the interface joining the watchdog device end and the core end.
// Assumes one clock domain and the interface signals wired in as plain inputs.
`timescale 1ns/1ps
module wdg_properties
    import wdg_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic vector_ack,
    input wire logic irq,
    input wire logic safety_level_fuse,
    input wire logic wdg_reset_pulse
);
    // ==========================================================
    // Clocking.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // ==========================================================
    // Assertions.
    a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("Read data not zero outside a read answer.");
    a_unmapped_read_zero: assert property ($past(rd_en) && $past(addr) != WDG_ADDR_CTRL
        && $past(addr) != WDG_ADDR_FLAGS |-> rdata == 8'h00)
        else $error("Unmapped read returned non-zero data.");
    a_flags_reserved_zero: assert property ($past(rd_en) && $past(addr) == WDG_ADDR_FLAGS
        |-> rdata[7:4] == 4'h0)
        else $error("Reset cause reserved bits not zero.");
    a_ctrl_reserved_zero: assert property ($past(rd_en) && $past(addr) == WDG_ADDR_CTRL
        |-> !rdata[4])
        else $error("Control reserved bit not zero.");
    a_level_two_enable: assert property (safety_level_fuse && $past(safety_level_fuse)
        && $past(rd_en) && $past(addr) == WDG_ADDR_CTRL |-> rdata[WDG_BIT_RST_EN])
        else $error("Reset enable read zero at safety level two.");
    a_reset_pulse_one: assert property (wdg_reset_pulse |=> !wdg_reset_pulse)
        else $error("Watchdog reset pulse longer than one cycle.");
    a_unlock_then_write: assert property (wr_en && addr == WDG_ADDR_UNLOCK
        |-> wdata == WDG_UNLOCK_SIG ##1 (wr_en && addr != WDG_ADDR_UNLOCK))
        else $error("Unlock write without signature or following write.");
    a_vector_drops_irq: assert property (vector_ack && irq |-> ##[1:2] !irq)
        else $error("Request stayed up after the vector.");

    // ==========================================================
    // Covers.
    c_ctrl_read: cover property (rd_en && addr == WDG_ADDR_CTRL);
    c_unlock: cover property (wr_en && addr == WDG_ADDR_UNLOCK);
    c_level_two_read: cover property (safety_level_fuse && rd_en);
endmodule
